// ---- rtl/actsc_clock_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Retimed stamp repeats on trigger in mode 3.
// - Stamp replaces sample bit 0 when enabled.
// - Stamp sampled with data-path matched latency.
// - PLL pin high selects PLL reference input.
// - Both pins low bypasses PLL, differential clock.
// - Reference repeat on with PLL, enable bit.
// - Repeat output follows selected reference input.
// - Power-down pin stops all clock outputs.
// - Channel C/D pins carry reference copies.
// - Sample rate is reference times feedback divider.
// - Calibration runs when PLL reset clears and the cal enable bit is set.
// - Done and lock registers report completion.
// - Noise-suppression bits for two supply domains.
// - Trigger output off until enabled.
// - Serial-link mode outputs line clock over twice the divider.
// - Serial-link clock derived from line clock ticks.
// - Sync captured on i_mclk through a two-stage synchroniser.
module actsc_clock_ctrl #(
	parameter int CAL_COUNT   = actsc_pkg::CAL_CYCLES,
	parameter int LOCK_COUNT  = actsc_pkg::LOCK_CYCLES,
	parameter int PIPE_DEPTH  = 4,
	parameter int SAMPLE_W    = actsc_pkg::SAMPLE_BITS
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_rstn,
	input  wire actsc_pkg::actsc_reg_req_t i_reg_req,
	output logic [7:0]                  o_reg_rdata,
	output logic                        o_reg_rvalid,
	input  wire logic                   i_pll_enable_pin,
	input  wire logic                   i_reference_select_pin,
	input  wire logic                   i_power_down_pin,
	input  wire logic [1:0]             i_clock_config_pins,
	input  wire logic                   i_diff_clock,
	input  wire logic                   i_single_ended_clock_input,
	input  wire logic                   i_sysref,
	input  wire logic                   i_timestamp_input,
	input  wire logic                   i_line_clock_tick,
	input  wire logic [SAMPLE_W-1:0]    i_sample,
	input  wire logic                   i_sample_valid,
	output logic [SAMPLE_W-1:0]         o_link_word,
	output logic                        o_link_valid,
	output logic                        o_trigger_clock_output,
	output logic                        o_trigger_output_active,
	output logic                        o_reference_repeat_output,
	output logic                        o_reference_repeat_active,
	output logic                        o_channel_c_flag_pin,
	output logic                        o_channel_d_flag_pin,
	output logic                        o_sysref_captured,
	output logic                        o_use_pll,
	output logic                        o_pll_ref_is_single_ended,
	output logic [7:0]                  o_pv_divider,
	output logic [7:0]                  o_feedback_divider,
	output logic [actsc_pkg::NOISE_BITS-1:0] o_noise_suppress
);
	// ========================================================================
	// Pin synchronisers
	// ========================================================================
	logic [1:0] pll_en_s_q, ref_sel_s_q, pd_s_q, stamp_s_q, sysref_s_q;
	logic [1:0] ccfg0_s_q, ccfg1_s_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pll_en_s_q  <= 2'h0;
			ref_sel_s_q <= 2'h0;
			pd_s_q      <= 2'h3;
			stamp_s_q   <= 2'h0;
			sysref_s_q  <= 2'h0;
			ccfg0_s_q   <= 2'h0;
			ccfg1_s_q   <= 2'h0;
		end else begin
			pll_en_s_q  <= {pll_en_s_q[0], i_pll_enable_pin};
			ref_sel_s_q <= {ref_sel_s_q[0], i_reference_select_pin};
			pd_s_q      <= {pd_s_q[0], i_power_down_pin};
			stamp_s_q   <= {stamp_s_q[0], i_timestamp_input};
			sysref_s_q  <= {sysref_s_q[0], i_sysref};
			ccfg0_s_q   <= {ccfg0_s_q[0], i_clock_config_pins[0]};
			ccfg1_s_q   <= {ccfg1_s_q[0], i_clock_config_pins[1]};
		end
	end
	wire pll_en  = pll_en_s_q[1];
	wire ref_sel = ref_sel_s_q[1];
	wire pd      = pd_s_q[1];
	wire [1:0] ccfg = {ccfg1_s_q[1], ccfg0_s_q[1]};

	// ========================================================================
	// Registers
	// ========================================================================
	logic [7:0] pv_q, n_q, noise_q, prst_q, calen_q, trig_q, clkc_q, stamp_q, divref_q;
	logic       cal_done_q, locked_q;
	actsc_pkg::actsc_pll_state_t state_q, state_d;

	wire wr = i_reg_req.wr;
	wire [14:0] a = i_reg_req.addr;
	wire [7:0] wd = i_reg_req.wdata;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pv_q     <= actsc_pkg::RST_PV_DIV;
			n_q      <= actsc_pkg::RST_N_DIV;
			noise_q  <= actsc_pkg::RST_NOISE;
			prst_q   <= actsc_pkg::RST_PLL_RESET;
			calen_q  <= actsc_pkg::RST_CAL_EN;
			trig_q   <= actsc_pkg::RST_TRIG_CTRL;
			clkc_q   <= actsc_pkg::RST_CLK_CTRL;
			stamp_q  <= actsc_pkg::RST_STAMP_CTRL;
			divref_q <= actsc_pkg::RST_DIVREF;
		end else if (wr) begin
			if (a == actsc_pkg::ADDR_PV_DIV) pv_q <= wd;
			if (a == actsc_pkg::ADDR_N_DIV) n_q <= wd;
			if (a == actsc_pkg::ADDR_NOISE_CTRL) noise_q <= wd;
			if (a == actsc_pkg::ADDR_PLL_RESET) prst_q <= {7'h00, wd[0]};
			if (a == actsc_pkg::ADDR_CAL_EN) calen_q <= {7'h00, wd[0]};
			if (a == actsc_pkg::ADDR_TRIG_CTRL) trig_q <= wd;
			if (a == actsc_pkg::ADDR_CLK_CTRL) clkc_q <= {7'h00, wd[0]};
			if (a == actsc_pkg::ADDR_STAMP_CTRL) stamp_q <= {6'h00, wd[1:0]};
			if (a == actsc_pkg::ADDR_DIVREF_CTRL) divref_q <= {3'h0, wd[4:0]};
		end
	end

	// ========================================================================
	// PLL reset, calibration and lock sequence
	// ========================================================================
	logic [15:0] cnt_q, cnt_d;
	wire pll_held = prst_q[0] || !pll_en;
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + 16'h0001;
		case (state_q)
			actsc_pkg::PLL_HELD: begin
				cnt_d = 16'h0000;
				if (!pll_held) state_d = calen_q[0] ? actsc_pkg::PLL_CAL : actsc_pkg::PLL_LOCKING;
			end
			actsc_pkg::PLL_CAL: begin
				if (cnt_q == 16'(CAL_COUNT - 1)) begin
					state_d = actsc_pkg::PLL_LOCKING;
					cnt_d   = 16'h0000;
				end
			end
			actsc_pkg::PLL_LOCKING: begin
				if (cnt_q == 16'(LOCK_COUNT - 1)) state_d = actsc_pkg::PLL_LOCKED;
			end
			actsc_pkg::PLL_LOCKED: cnt_d = cnt_q;
			default: state_d = actsc_pkg::PLL_HELD;
		endcase
		if (pll_held) state_d = actsc_pkg::PLL_HELD;
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q    <= actsc_pkg::PLL_HELD;
			cnt_q      <= 16'h0000;
			cal_done_q <= 1'b0;
			locked_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			locked_q <= (state_d == actsc_pkg::PLL_LOCKED);
			if (pll_held) cal_done_q <= 1'b0;
			else if (state_q == actsc_pkg::PLL_CAL && state_d == actsc_pkg::PLL_LOCKING)
				cal_done_q <= 1'b1;
		end
	end

	// ========================================================================
	// Register read
	// ========================================================================
	logic [7:0] rd_d;
	always_comb begin
		case (a)
			actsc_pkg::ADDR_PV_DIV:      rd_d = pv_q;
			actsc_pkg::ADDR_N_DIV:       rd_d = n_q;
			actsc_pkg::ADDR_NOISE_CTRL:  rd_d = noise_q;
			actsc_pkg::ADDR_PLL_RESET:   rd_d = prst_q;
			actsc_pkg::ADDR_CAL_EN:      rd_d = calen_q;
			actsc_pkg::ADDR_CAL_DONE:    rd_d = {7'h00, cal_done_q};
			actsc_pkg::ADDR_LOCK_STATUS: rd_d = {7'h00, locked_q};
			actsc_pkg::ADDR_TRIG_CTRL:   rd_d = trig_q;
			actsc_pkg::ADDR_CLK_CTRL:    rd_d = clkc_q;
			actsc_pkg::ADDR_STAMP_CTRL:  rd_d = stamp_q;
			actsc_pkg::ADDR_DIVREF_CTRL: rd_d = divref_q;
			default:                     rd_d = 8'h00;
		endcase
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_req.rd;
			if (i_reg_req.rd) o_reg_rdata <= rd_d;
		end
	end

	// ========================================================================
	// Clock source selection and outputs
	// ========================================================================
	// The single-ended input is only ever routed through the PLL reference.
	wire sel_ref_clk = (pll_en && ref_sel) ? i_single_ended_clock_input : i_diff_clock;
	wire ref_rep_on  = pll_en && !pd && clkc_q[0];

	// Divided copies for channel C/D pins, counted on this clock.
	logic [1:0] ref_div_q;
	logic       ref_last_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ref_div_q  <= 2'h0;
			ref_last_q <= 1'b0;
		end else begin
			ref_last_q <= sel_ref_clk;
			if (sel_ref_clk && !ref_last_q) ref_div_q <= ref_div_q + 2'h1;
		end
	end
	wire        ovr_en   = divref_q[4];
	wire [1:0]  c_mode   = ovr_en ? divref_q[1:0] : ccfg;
	wire [1:0]  d_mode   = ovr_en ? divref_q[3:2] : ((ccfg != 2'h0) ? actsc_pkg::DIVREF_DIRECT : 2'h0);
	function automatic logic pick(input logic [1:0] m, input logic r, input logic [1:0] dv);
		case (m)
			actsc_pkg::DIVREF_DIRECT:  pick = r;
			actsc_pkg::DIVREF_HALF:    pick = dv[0];
			actsc_pkg::DIVREF_QUARTER: pick = dv[1];
			default:                   pick = 1'b0;
		endcase
	endfunction : pick
	wire c_out = !pd && pick(c_mode, sel_ref_clk, ref_div_q);
	wire d_out = !pd && (c_mode != 2'h0) && pick(d_mode, sel_ref_clk, ref_div_q);

	// ========================================================================
	// Timestamp path and trigger output
	// ========================================================================
	actsc_pkg::actsc_trig_ctrl_t tc;
	assign tc = trig_q;
	wire stamp_rx_en = stamp_q[0];
	wire stamp_bit   = stamp_rx_en && stamp_s_q[1];
	logic [PIPE_DEPTH-1:0] stamp_pipe_q;
	logic [4:0]            rx_cnt_q;
	logic                  spll_clk_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			stamp_pipe_q <= '0;
			rx_cnt_q     <= 5'h00;
			spll_clk_q   <= 1'b0;
		end else begin
			if (i_sample_valid) stamp_pipe_q <= {stamp_pipe_q[PIPE_DEPTH-2:0], stamp_bit};
			if (i_line_clock_tick) begin
				if (rx_cnt_q >= tc.rx_div - 5'h01) begin
					rx_cnt_q   <= 5'h00;
					spll_clk_q <= !spll_clk_q;
				end else rx_cnt_q <= rx_cnt_q + 5'h01;
			end
		end
	end
	wire trig_stamp = tc.trig_enable && tc.trig_mode == actsc_pkg::TRIG_MODE_STAMP;
	wire trig_spll  = tc.trig_enable && tc.trig_mode == actsc_pkg::TRIG_MODE_SPLL;
	wire trig_d     = !pd && ((trig_stamp && stamp_bit) || (trig_spll && spll_clk_q));
	wire [SAMPLE_W-1:0] word_d = (stamp_q[1] && stamp_rx_en) ?
		{i_sample[SAMPLE_W-1:1], stamp_pipe_q[PIPE_DEPTH-1]} : i_sample;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_link_word               <= '0;
			o_link_valid              <= 1'b0;
			o_trigger_clock_output    <= 1'b0;
			o_reference_repeat_output <= 1'b0;
			o_channel_c_flag_pin      <= 1'b0;
			o_channel_d_flag_pin      <= 1'b0;
			o_sysref_captured         <= 1'b0;
		end else begin
			o_link_valid              <= i_sample_valid;
			if (i_sample_valid) o_link_word <= word_d;
			o_trigger_clock_output    <= trig_d;
			o_reference_repeat_output <= ref_rep_on && sel_ref_clk;
			o_channel_c_flag_pin      <= c_out;
			o_channel_d_flag_pin      <= d_out;
			o_sysref_captured         <= sysref_s_q[1];
		end
	end
	assign o_trigger_output_active   = !pd && (trig_stamp || trig_spll);
	assign o_reference_repeat_active = ref_rep_on;
	assign o_use_pll                 = pll_en;
	assign o_pll_ref_is_single_ended = pll_en && ref_sel;
	assign o_pv_divider              = pv_q;
	assign o_feedback_divider        = n_q;
	assign o_noise_suppress          = noise_q[actsc_pkg::NOISE_BITS-1:0];
endmodule : actsc_clock_ctrl

// ---- inc/actsc_pkg.sv ----
package actsc_pkg;
	// ========================================================================
	// Register map
	// ========================================================================
	localparam logic [14:0] ADDR_NOISE_CTRL  = 15'h002b;
	localparam logic [14:0] ADDR_PV_DIV      = 15'h003d;
	localparam logic [14:0] ADDR_N_DIV       = 15'h003e;
	localparam logic [14:0] ADDR_PLL_RESET   = 15'h005c;
	localparam logic [14:0] ADDR_CAL_EN      = 15'h005d;
	localparam logic [14:0] ADDR_CAL_DONE    = 15'h005e;
	localparam logic [14:0] ADDR_LOCK_STATUS = 15'h0208;
	localparam logic [14:0] ADDR_TRIG_CTRL   = 15'h0060;
	localparam logic [14:0] ADDR_CLK_CTRL    = 15'h0061;
	localparam logic [14:0] ADDR_STAMP_CTRL  = 15'h0062;
	localparam logic [14:0] ADDR_DIVREF_CTRL = 15'h0063;

	// ========================================================================
	// Reset values and field positions
	// ========================================================================
	localparam logic [7:0] RST_PV_DIV     = 8'h00;
	localparam logic [7:0] RST_N_DIV      = 8'h00;
	localparam logic [7:0] RST_NOISE      = 8'h00;
	localparam logic [7:0] RST_PLL_RESET  = 8'h01;
	localparam logic [7:0] RST_CAL_EN     = 8'h00;
	localparam logic [7:0] RST_TRIG_CTRL  = 8'h00;
	localparam logic [7:0] RST_CLK_CTRL   = 8'h01;
	localparam logic [7:0] RST_STAMP_CTRL = 8'h00;
	localparam logic [7:0] RST_DIVREF     = 8'h00;
	localparam logic [1:0] TRIG_MODE_STAMP = 2'h3;
	localparam logic [1:0] TRIG_MODE_SPLL  = 2'h1;
	localparam logic [1:0] DIVREF_DIRECT   = 2'h1;
	localparam logic [1:0] DIVREF_HALF     = 2'h2;
	localparam logic [1:0] DIVREF_QUARTER  = 2'h3;
	localparam int         NOISE_BITS      = 2;
	localparam int         SAMPLE_BITS     = 12;

	// ========================================================================
	// Timing
	// ========================================================================
	localparam int CLK_PERIOD_NS     = 5;
	localparam int CAL_TIME_NS       = 1000;
	localparam int CAL_CYCLES        = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_TIME_NS      = 500;
	localparam int LOCK_CYCLES       = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ========================================================================
	// Types
	// ========================================================================
	typedef enum logic [1:0] {
		PLL_HELD    = 2'b00,
		PLL_CAL     = 2'b01,
		PLL_LOCKING = 2'b10,
		PLL_LOCKED  = 2'b11
	} actsc_pll_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [14:0] addr;
		logic [7:0] wdata;
	} actsc_reg_req_t;

	typedef struct packed {
		logic trig_enable;
		logic [1:0] trig_mode;
		logic [4:0] rx_div;
	} actsc_trig_ctrl_t;
endpackage : actsc_pkg

// ---- verification/actsc_fpga_model.sv ----
`timescale 1ns/1ps
module actsc_fpga_model (
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	input  wire logic       i_clear,
	input  wire logic       i_trigger_clock,
	output logic [7:0]      o_edge_count
);
	logic       trig_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	// The receiver counts rising edges of the forwarded link clock.
	assign cnt_d = (i_trigger_clock && !trig_q) ? cnt_q + 8'h01 : cnt_q;
	assign o_edge_count = cnt_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			trig_q <= 1'b0;
			cnt_q  <= 8'h00;
		end else begin
			trig_q <= i_trigger_clock;
			cnt_q  <= i_clear ? 8'h00 : cnt_d;
		end
	end
endmodule : actsc_fpga_model

// ---- verification/actsc_clock_monitor.sv ----
`timescale 1ns/1ps
module actsc_clock_monitor #(
	parameter int SAMPLE_W = 12
) (
	input wire logic                      i_mclk,
	input wire logic                      i_rstn,
	input wire actsc_pkg::actsc_reg_req_t i_reg_req,
	input wire logic                      o_reg_rvalid,
	input wire logic                      i_pll_enable_pin,
	input wire logic                      i_reference_select_pin,
	input wire logic                      i_power_down_pin,
	input wire logic [SAMPLE_W-1:0]       i_sample,
	input wire logic                      i_sample_valid,
	input wire logic [SAMPLE_W-1:0]       o_link_word,
	input wire logic                      o_link_valid,
	input wire logic                      o_trigger_output_active,
	input wire logic                      o_reference_repeat_output,
	input wire logic                      o_reference_repeat_active,
	input wire logic                      o_use_pll,
	input wire logic                      o_pll_ref_is_single_ended,
	input wire logic [7:0]                o_feedback_divider
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	sequence pd_held;
		i_power_down_pin [*4];
	endsequence
	sequence n_write;
		i_reg_req.wr && i_reg_req.addr == actsc_pkg::ADDR_N_DIV;
	endsequence
	a_read_answer: assert property (i_reg_req.rd |=> o_reg_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_req.rd))
		else $error("stray read answer");
	a_pd_quiet: assert property (pd_held |-> !(o_reference_repeat_active
		|| o_reference_repeat_output || o_trigger_output_active)) else $error("output in pd");
	a_repeat_needs_pll: assert property (!i_pll_enable_pin [*3] |-> !o_reference_repeat_active)
		else $error("repeat without pll");
	a_bypass_mode: assert property ((!i_pll_enable_pin && !i_reference_select_pin) [*3]
		|-> !o_use_pll && !o_pll_ref_is_single_ended) else $error("bypass wrong");
	a_pll_select: assert property (i_pll_enable_pin [*3] |-> o_use_pll
		&& o_pll_ref_is_single_ended == $past(i_reference_select_pin, 2)) else $error("ref select");
	a_link_upper: assert property (o_link_valid |-> $past(i_sample_valid)
		&& o_link_word[SAMPLE_W-1:1] == $past(i_sample[SAMPLE_W-1:1])) else $error("link word");
	a_feedback_copy: assert property (n_write |=> o_feedback_divider == $past(i_reg_req.wdata))
		else $error("divider copy");
endmodule : actsc_clock_monitor

bind actsc_clock_ctrl actsc_clock_monitor #(.SAMPLE_W(SAMPLE_W)) i_actsc_clock_monitor (
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_req(i_reg_req), .o_reg_rvalid(o_reg_rvalid),
	.i_pll_enable_pin(i_pll_enable_pin), .i_reference_select_pin(i_reference_select_pin),
	.i_power_down_pin(i_power_down_pin), .i_sample(i_sample), .i_sample_valid(i_sample_valid),
	.o_link_word(o_link_word), .o_link_valid(o_link_valid),
	.o_trigger_output_active(o_trigger_output_active),
	.o_reference_repeat_output(o_reference_repeat_output),
	.o_reference_repeat_active(o_reference_repeat_active), .o_use_pll(o_use_pll),
	.o_pll_ref_is_single_ended(o_pll_ref_is_single_ended),
	.o_feedback_divider(o_feedback_divider));

// ---- verification/adc_clock_and_timestamp_control_tb.sv ----
`timescale 1ns/1ps
module adc_clock_and_timestamp_control_tb;
	logic                      i_mclk = 1'b0;
	logic                      i_rstn = 1'b0;
	actsc_pkg::actsc_reg_req_t req = '0;
	logic                      pll_en = 1'b1, ref_se = 1'b0, pd = 1'b0, stamp = 1'b0;
	logic                      dclk = 1'b0, sclk = 1'b0, tick = 1'b0, svalid = 1'b0, clr = 1'b0;
	logic [11:0]               sample = '0, lword;
	logic [7:0]                rdata, nedge;
	logic [1:0]                noise;
	logic                      channel_c_flag_pin, channel_d_flag_pin;
	logic                      rvalid, lvalid, trig, trig_act, rep, rep_act, use_pll, ref_is_se;
	logic [15:0]               exp_rd[$], exp_lw[$];
	logic                      hist[$] = '{4{1'b0}};
	logic [7:0]                ctl[5] = '{8'h00, 8'h02, 8'h02, 8'h03, 8'h03};
	logic                      stv[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	int                        err_total = 0, tests_run = 0, cyc = 0;
	localparam string A = "ADDR";
	actsc_clock_ctrl #(.CAL_COUNT(4), .LOCK_COUNT(3)) i_actsc_clock_ctrl (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_req(req), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_pll_enable_pin(pll_en), .i_reference_select_pin(ref_se),
		.i_power_down_pin(pd), .i_clock_config_pins(2'h1), .i_diff_clock(dclk),
		.i_single_ended_clock_input(sclk), .i_sysref(1'b0), .i_timestamp_input(stamp),
		.i_line_clock_tick(tick), .i_sample(sample), .i_sample_valid(svalid),
		.o_link_word(lword), .o_link_valid(lvalid), .o_trigger_clock_output(trig),
		.o_trigger_output_active(trig_act), .o_reference_repeat_output(rep),
		.o_reference_repeat_active(rep_act), .o_channel_c_flag_pin(channel_c_flag_pin), .o_channel_d_flag_pin(channel_d_flag_pin),
		.o_sysref_captured(), .o_use_pll(use_pll), .o_pll_ref_is_single_ended(ref_is_se),
		.o_pv_divider(), .o_feedback_divider(), .o_noise_suppress(noise));
	actsc_fpga_model i_actsc_fpga_model (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_clear(clr),
		.i_trigger_clock(trig), .o_edge_count(nedge));
	always #2.5 i_mclk = ~i_mclk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	task automatic settle(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : settle
	// A read notes its expected data; w=1 writes d, w=0 reads and expects d.
	task automatic bus(input logic w, input logic [14:0] a, input logic [7:0] d);
		if (!w) exp_rd.push_back({8'h00, d});
		@(posedge i_mclk);
		req <= '{wr: w, rd: !w, addr: a, wdata: w ? d : 8'h00};
		@(posedge i_mclk);
		req <= '0;
	endtask : bus
	task automatic send(input logic [7:0] c, input int n);
		logic [11:0] s;
		repeat (n) begin
			s = 12'($urandom);
			hist.push_back(stamp && c == 8'h03);
			exp_lw.push_back(c == 8'h03 ? {4'h0, s[11:1], hist[hist.size() - 5]} : {4'h0, s});
			@(posedge i_mclk);
			sample <= s;
			svalid <= 1'b1;
		end
		@(posedge i_mclk);
		svalid <= 1'b0;
	endtask : send
	always @(posedge i_mclk) begin
		if (rvalid === 1'b1) chk({8'h00, rdata}, exp_rd.pop_front());
		if (lvalid === 1'b1) chk({4'h0, lword}, exp_lw.pop_front());
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		logic [7:0] r;
		void'($urandom(69));
		repeat (12) @(posedge i_mclk);
		i_rstn <= 1'b1;
		settle(1);
		chk({15'h0, trig_act}, 16'h0);
		bus(1'b0, actsc_pkg::ADDR_PLL_RESET, 8'h01);
		bus(1'b0, actsc_pkg::ADDR_CLK_CTRL, 8'h01);
		bus(1'b0, actsc_pkg::ADDR_CAL_DONE, 8'h00);
		bus(1'b0, actsc_pkg::ADDR_PV_DIV, 8'h00);
		bus(1'b0, 15'h7fff, 8'h00);
		bus(1'b1, actsc_pkg::ADDR_LOCK_STATUS, 8'hff);
		bus(1'b0, actsc_pkg::ADDR_LOCK_STATUS, 8'h00);
		$display("reset values done");
		r = 8'($urandom);
		bus(1'b1, actsc_pkg::ADDR_PLL_RESET, 8'h01);
		bus(1'b1, actsc_pkg::ADDR_PV_DIV, r);
		bus(1'b1, actsc_pkg::ADDR_N_DIV, 8'h0a);
		bus(1'b1, actsc_pkg::ADDR_NOISE_CTRL, 8'h03);
		bus(1'b1, actsc_pkg::ADDR_CAL_EN, 8'h01);
		bus(1'b1, actsc_pkg::ADDR_PLL_RESET, 8'h00);
		bus(1'b0, actsc_pkg::ADDR_CAL_DONE, 8'h00);
		settle(11);
		bus(1'b0, actsc_pkg::ADDR_CAL_DONE, 8'h01);
		bus(1'b0, actsc_pkg::ADDR_LOCK_STATUS, 8'h01);
		bus(1'b0, actsc_pkg::ADDR_PV_DIV, r);
		bus(1'b1, actsc_pkg::ADDR_PLL_RESET, 8'h01);
		bus(1'b0, actsc_pkg::ADDR_LOCK_STATUS, 8'h00);
		bus(1'b0, actsc_pkg::ADDR_CAL_DONE, 8'h00);
		chk({14'h0, noise}, 16'h3);
		$display("pll sequence done");
		bus(1'b1, actsc_pkg::ADDR_CLK_CTRL, 8'h00);
		settle(2);
		chk({15'h0, rep_act}, 16'h0);
		bus(1'b1, actsc_pkg::ADDR_CLK_CTRL, 8'h01);
		for (int k = 0; k < 4; k++) begin
			@(posedge i_mclk);
			ref_se <= k[0];
			dclk <= k[1];
			sclk <= !k[1];
			settle(5);
			chk({14'h0, rep_act, rep}, {14'h0, 1'b1, k[0] ^ k[1]});
			chk({14'h0, use_pll, ref_is_se}, {14'h0, 1'b1, k[0]});
			chk({14'h0, channel_c_flag_pin, channel_d_flag_pin}, {14'h0, {2{k[0] ^ k[1]}}});
		end
		@(posedge i_mclk);
		pd <= 1'b1;
		settle(5);
		chk({14'h0, rep_act, rep}, 16'h0);
		chk({14'h0, channel_c_flag_pin, channel_d_flag_pin}, 16'h0);
		@(posedge i_mclk);
		pd <= 1'b0;
		pll_en <= 1'b0;
		ref_se <= 1'b0;
		settle(5);
		chk({13'h0, rep_act, use_pll, ref_is_se}, 16'h0);
		@(posedge i_mclk);
		pll_en <= 1'b1;
		$display("clock select done");
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, actsc_pkg::ADDR_STAMP_CTRL, ctl[k]);
			@(posedge i_mclk);
			stamp <= stv[k];
			settle(4);
			send(ctl[k], 6);
		end
		$display("stamp stream done");
		bus(1'b1, actsc_pkg::ADDR_TRIG_CTRL, 8'h60);
		@(posedge i_mclk);
		stamp <= 1'b1;
		settle(6);
		chk({14'h0, trig_act, trig}, 16'h0);
		bus(1'b1, actsc_pkg::ADDR_TRIG_CTRL, 8'he0);
		settle(6);
		chk({14'h0, trig_act, trig}, 16'h3);
		@(posedge i_mclk);
		stamp <= 1'b0;
		settle(6);
		chk({14'h0, trig_act, trig}, 16'h2);
		bus(1'b1, actsc_pkg::ADDR_TRIG_CTRL, 8'ha2);
		clr <= 1'b1;
		tick <= 1'b1;
		@(posedge i_mclk);
		clr <= 1'b0;
		settle(40);
		chk({15'h0, nedge >= 8'h09 && nedge <= 8'h0b}, 16'h1);
		tick <= 1'b0;
		settle(4);
		chk(16'(exp_lw.size() + exp_rd.size()), 16'h0);
		$display("trigger output done");
		final_report();
	end
endmodule : adc_clock_and_timestamp_control_tb
